// ---- design/dfe_pkg.sv ----
// Types shared by the fault encoder modules
package dfe_pkg;
  typedef enum logic [2:0] {
    DFE_NONE, DFE_OVER, DFE_UNDER, DFE_PATH, DFE_HOT, DFE_COLD,
    DFE_RANGE_LO, DFE_RANGE_HI
  } dfe_fault_t;
  typedef enum logic [1:0] {
    DFE_OUT_NORMAL, DFE_OUT_DIAG, DFE_OUT_HIZ
  } dfe_out_t;
endpackage : dfe_pkg

// ---- design/dfe_pwm_gen.sv ----
// Diagnostic PWM generator at half carrier frequency
`timescale 1ns/10ps
`include "dfe_regs.svh"
module dfe_pwm_gen (
  input wire logic clk_sys,
  input wire logic resetn,
  dfe_pwm_if.gen   pif
);
  logic [16:0] cnt_ff;
  logic        pwm_ff;
  logic [16:0] dbl_period;
  logic [26:0] high_time;
  assign dbl_period = {pif.period, 1'b0};
  assign high_time  = 27'(dbl_period) * 27'(pif.duty);

  // Period counter, double carrier period
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= 17'h0_0000;
    end else if (!pif.diag_on || cnt_ff + 17'h0_0001 >= dbl_period) begin
      cnt_ff <= 17'h0_0000;
    end else begin
      cnt_ff <= cnt_ff + 17'h0_0001;
    end
  end

  // High while count below duty fraction
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pwm_ff <= 1'b0;
    end else begin
      pwm_ff <= pif.diag_on &&
                (27'(cnt_ff) * 27'(`DFE_DUTY_FULL) < high_time);
    end
  end
  assign pif.pwm = pwm_ff;
endmodule : dfe_pwm_gen

// ---- design/dfe_pwm_if.sv ----
// Interface between fault selector and diagnostic PWM generator
`timescale 1ns/10ps
interface dfe_pwm_if;
  logic        diag_on;
  logic [9:0]  duty;
  logic [15:0] period;
  logic        pwm;
  modport ctrl (output diag_on, output duty, output period, input pwm);
  modport gen  (input diag_on, input duty, input period, output pwm);
endinterface : dfe_pwm_if

// ---- design/dfe_regs.svh ----
// Offsets, fields, reset values and timing counts of the fault encoder
`ifndef DFE_REGS_SVH
`define DFE_REGS_SVH
`define DFE_OFF_FAULT_WORD   8'h00
`define DFE_OFF_CONFIG       8'h04
`define DFE_OFF_DETECT       8'h08
`define DFE_OFF_STATUS       8'h0c
`define DFE_OFF_CARRIER      8'h10
`define DFE_FW_MEM_DBE       0
`define DFE_FW_PATH          2
`define DFE_FW_UNDER         3
`define DFE_FW_OVER          4
`define DFE_FW_TEMP          5
`define DFE_FW_RANGE_LO      6
`define DFE_FW_RANGE_HI      7
`define DFE_CFG_OV_OFF       0
`define DFE_CFG_UV_OFF       1
`define DFE_CFG_TMP_OFF      2
`define DFE_CFG_OOR_OFF      3
`define DFE_CFG_OV_EN        4
`define DFE_CFG_UV_EN        5
`define DFE_CFG_PATH_EN      6
`define DFE_CFG_TMP_EN       7
`define DFE_CFG_OOR_EN       8
`define DFE_CFG_ADV_FLAG     9
`define DFE_CFG_HIZ_MODE     10
`define DFE_CFG_PM_LO        12
`define DFE_CFG_LOCK_LO      16
`define DFE_CFG_RESET        32'h0000_2000
`define DFE_LOCK_SET         4'hc
`define DFE_PM_CFG_MAX       2'h2
`define DFE_CARRIER_RESET    16'h03e8
// Duty cycles in tenths of a percent
`define DFE_DUTY_OVER        10'd404
`define DFE_DUTY_UNDER       10'd116
`define DFE_DUTY_PATH        10'd308
`define DFE_DUTY_HOT         10'd500
`define DFE_DUTY_COLD        10'd596
`define DFE_DUTY_RANGE_LO    10'd692
`define DFE_DUTY_RANGE_HI    10'd788
`define DFE_DUTY_FULL        10'd1000
`endif

// ---- design/dfe_top.sv ----
// Fault output encoder with AXI4-Lite register access
//
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/10ps
`include "dfe_regs.svh"
module dfe_top (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  input  wire logic        fault_overvoltage,
  input  wire logic        fault_undervoltage,
  input  wire logic        fault_path_monitor,
  input  wire logic        fault_over_temp,
  input  wire logic        fault_under_temp,
  input  wire logic        fault_range_low,
  input  wire logic        fault_range_high,
  input  wire logic        fault_mem_double,
  input  wire logic        normal_pwm,
  input  wire logic        normal_sent,
  output logic             out_level,
  output logic             out_oe_n,
  output logic [1:0]       status_comm_nibble,
  output logic             sent_hiz,
  output logic             prog_mode
);
  logic [31:0] cfg_ff;
  logic [15:0] carrier_ff;
  logic [7:0]  fault_word_ff;
  logic [7:0]  nxt_fault_word;
  logic [1:0]  nibble_ff;
  logic [1:0]  nxt_nibble;
  logic        out_ff;
  logic        oe_n_ff;
  logic        sent_hiz_ff;
  logic        prog_ff;
  logic [2:0]  sync_ff [8];
  logic [7:0]  det;
  dfe_pkg::dfe_fault_t sel;
  dfe_pkg::dfe_out_t   mode;
  logic        aw_ok_ff;
  logic        w_ok_ff;
  logic [7:0]  aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0]  w_strb_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic        locked;
  logic        ov_act;
  logic        uv_act;
  logic        pm_act;
  logic        tmp_en;
  logic        oor_act;
  logic [7:0]  raw;
  dfe_pwm_if   pif ();

  // Fault inputs pass three flops, level taken when stages 2,3 agree
  genvar gi;
  assign raw = {fault_mem_double, fault_range_high, fault_range_low,
                fault_under_temp, fault_over_temp, fault_path_monitor,
                fault_undervoltage, fault_overvoltage};
  generate
    for (gi = 0; gi < 8; gi++) begin : g_sync
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          sync_ff[gi] <= 3'h0;
          det[gi]     <= 1'b0;
        end else begin
          sync_ff[gi] <= {sync_ff[gi][1:0], raw[gi]};
          if (sync_ff[gi][1] == sync_ff[gi][2]) det[gi] <= sync_ff[gi][2];
        end
      end
    end
  endgenerate

  // Enable qualification from configuration
  assign locked   = cfg_ff[`DFE_CFG_LOCK_LO +: 4] == `DFE_LOCK_SET;
  assign ov_act   = cfg_ff[`DFE_CFG_OV_EN] && !cfg_ff[`DFE_CFG_OV_OFF]
                    && locked;
  assign uv_act   = cfg_ff[`DFE_CFG_UV_EN]
                    && !cfg_ff[`DFE_CFG_UV_OFF];
  assign pm_act   = cfg_ff[`DFE_CFG_PATH_EN] &&
                    cfg_ff[`DFE_CFG_PM_LO +: 2] <= `DFE_PM_CFG_MAX;
  assign tmp_en   = cfg_ff[`DFE_CFG_TMP_EN]
                    && !cfg_ff[`DFE_CFG_TMP_OFF];
  assign oor_act  = cfg_ff[`DFE_CFG_OOR_EN] && cfg_ff[`DFE_CFG_ADV_FLAG]
                    && !cfg_ff[`DFE_CFG_OOR_OFF];

  // Fault word, nibble and priority selection
  always_comb begin
    nxt_fault_word = 8'h00;
    sel            = dfe_pkg::DFE_NONE;
    if (det[7]) nxt_fault_word[`DFE_FW_MEM_DBE] = 1'b1;
    if (det[6] && oor_act) begin
      nxt_fault_word[`DFE_FW_RANGE_HI] = 1'b1;
      sel = dfe_pkg::DFE_RANGE_HI;
    end
    if (det[5] && oor_act) begin
      nxt_fault_word[`DFE_FW_RANGE_LO] = 1'b1;
      sel = dfe_pkg::DFE_RANGE_LO;
    end
    if (det[4] && tmp_en) begin
      nxt_fault_word[`DFE_FW_TEMP] = 1'b1;
      sel = dfe_pkg::DFE_COLD;
    end
    if (det[3] && tmp_en) begin
      nxt_fault_word[`DFE_FW_TEMP] = 1'b1;
      sel = dfe_pkg::DFE_HOT;
    end
    if (det[1] && uv_act) begin
      nxt_fault_word[`DFE_FW_UNDER] = 1'b1;
      sel = dfe_pkg::DFE_UNDER;
    end
    if (det[2] && pm_act) begin
      nxt_fault_word[`DFE_FW_PATH] = 1'b1;
      sel = dfe_pkg::DFE_PATH;
    end
    if (det[0] && ov_act) begin
      nxt_fault_word[`DFE_FW_OVER] = 1'b1;
      sel = dfe_pkg::DFE_OVER;
    end
    nxt_nibble[0] = nxt_fault_word[`DFE_FW_PATH];
    nxt_nibble[1] = |nxt_fault_word[`DFE_FW_RANGE_HI:`DFE_FW_UNDER];
  end

  // Output mode: memory fault and programming beat everything
  always_comb begin
    if (det[7] || (det[0] && !locked)) begin
      mode = dfe_pkg::DFE_OUT_HIZ;
    end else if (sel == dfe_pkg::DFE_NONE) begin
      mode = dfe_pkg::DFE_OUT_NORMAL;
    end else if (cfg_ff[`DFE_CFG_HIZ_MODE]) begin
      mode = dfe_pkg::DFE_OUT_HIZ;
    end else begin
      mode = dfe_pkg::DFE_OUT_DIAG;
    end
  end

  // Duty for selected fault
  always_comb begin
    unique case (sel)
      dfe_pkg::DFE_OVER:     pif.duty = `DFE_DUTY_OVER;
      dfe_pkg::DFE_UNDER:    pif.duty = `DFE_DUTY_UNDER;
      dfe_pkg::DFE_PATH:     pif.duty = `DFE_DUTY_PATH;
      dfe_pkg::DFE_HOT:      pif.duty = `DFE_DUTY_HOT;
      dfe_pkg::DFE_COLD:     pif.duty = `DFE_DUTY_COLD;
      dfe_pkg::DFE_RANGE_LO: pif.duty = `DFE_DUTY_RANGE_LO;
      dfe_pkg::DFE_RANGE_HI: pif.duty = `DFE_DUTY_RANGE_HI;
      dfe_pkg::DFE_NONE:     pif.duty = 10'd0;
    endcase
  end
  assign pif.diag_on = mode == dfe_pkg::DFE_OUT_DIAG;
  assign pif.period  = carrier_ff;

  dfe_pwm_gen u_pwm (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .pif     (pif)
  );

  // Registered outputs
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fault_word_ff <= 8'h00;
      nibble_ff     <= 2'h0;
      out_ff        <= 1'b0;
      oe_n_ff       <= 1'b1;
      sent_hiz_ff   <= 1'b0;
      prog_ff       <= 1'b0;
    end else begin
      fault_word_ff <= nxt_fault_word;
      nibble_ff     <= det[7] ? 2'h0 : nxt_nibble;
      sent_hiz_ff   <= mode == dfe_pkg::DFE_OUT_HIZ;
      prog_ff       <= det[0] && !locked;
      unique case (mode)
        dfe_pkg::DFE_OUT_DIAG:   {out_ff, oe_n_ff} <= {pif.pwm, 1'b0};
        dfe_pkg::DFE_OUT_NORMAL: {out_ff, oe_n_ff} <= {normal_pwm, 1'b0};
        default:                 {out_ff, oe_n_ff} <= 2'h1;
      endcase
    end
  end
  assign out_level          = out_ff;
  assign out_oe_n           = oe_n_ff;
  assign status_comm_nibble = nibble_ff;
  assign sent_hiz           = sent_hiz_ff;
  assign prog_mode          = prog_ff;

  // AXI write: address and data taken in either order
  assign s_axi_awready = !aw_ok_ff && !bvalid_ff;
  assign s_axi_wready  = !w_ok_ff && !bvalid_ff;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      aw_ok_ff   <= 1'b0;
      w_ok_ff    <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff  <= 32'h0000_0000;
      w_strb_ff  <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok_ff   <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok_ff   <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (aw_ok_ff && w_ok_ff) begin
        aw_ok_ff  <= 1'b0;
        w_ok_ff   <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff  <= (aw_addr_ff == `DFE_OFF_CONFIG ||
                      aw_addr_ff == `DFE_OFF_CARRIER) ? 2'h0 : 2'h2;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;

  // Writable configuration, byte lanes honoured
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cfg_ff     <= `DFE_CFG_RESET;
      carrier_ff <= `DFE_CARRIER_RESET;
    end else if (aw_ok_ff && w_ok_ff) begin
      for (int b = 0; b < 4; b++) begin
        if (w_strb_ff[b] && aw_addr_ff == `DFE_OFF_CONFIG)
          cfg_ff[8*b +: 8] <= w_data_ff[8*b +: 8];
      end
      for (int b = 0; b < 2; b++) begin
        if (w_strb_ff[b] && aw_addr_ff == `DFE_OFF_CARRIER)
          carrier_ff[8*b +: 8] <= w_data_ff[8*b +: 8];
      end
    end
  end

  // AXI read, unmapped answers SLVERR
  assign s_axi_arready = !rvalid_ff;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= 2'h0;
      unique case (s_axi_araddr)
        `DFE_OFF_FAULT_WORD: rdata_ff <= {24'h00_0000, fault_word_ff};
        `DFE_OFF_CONFIG:     rdata_ff <= cfg_ff;
        `DFE_OFF_DETECT:     rdata_ff <= {24'h00_0000, det};
        `DFE_OFF_STATUS:     rdata_ff <= {27'h000_0000, prog_ff,
                                          sent_hiz_ff, oe_n_ff, nibble_ff};
        `DFE_OFF_CARRIER:    rdata_ff <= {16'h0000, carrier_ff};
        default: begin
          rdata_ff <= 32'h0000_0000;
          rresp_ff <= 2'h2;
        end
      endcase
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata  = rdata_ff;
  assign s_axi_rresp  = rresp_ff;
endmodule : dfe_top

// ---- verification/dfe_ctrl_model.sv ----
// Controller-side model that measures the diagnostic waveform
`timescale 1ns/10ps
module dfe_ctrl_model (
  input  wire logic clk_sys,
  input  wire logic out_level,
  input  wire logic out_oe_n,
  output int        high_len,
  output int        per_len
);
  int   h = 0;
  int   p = 0;
  logic pin_q = 1'b1;
  logic pin;
  // Open-drain line with pull-up on the controller side
  assign pin = out_oe_n ? 1'b1 : out_level;
  // Rising edge to rising edge is one period
  always @(posedge clk_sys) begin
    if (pin && !pin_q) begin
      high_len <= h;
      per_len <= p;
      h = 0;
      p = 0;
    end
    p = p + 1;
    h = h + (pin ? 1 : 0);
    pin_q = pin;
  end
endmodule : dfe_ctrl_model

// ---- verification/dfe_top_chk.sv ----
// Assertion checker for the fault encoder top ports
`timescale 1ns/10ps
module dfe_top_chk (
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        fault_mem_double,
  input wire logic        out_oe_n,
  input wire logic        sent_hiz,
  input wire logic [1:0]  status_comm_nibble,
  input wire logic        prog_mode
);
  default clocking dfe_cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Memory fault outputs, past the synchroniser delay, and pin released in programming mode
  a_mem_oe_hiz: assert property (
    fault_mem_double [*8] |-> out_oe_n && sent_hiz)
    else $error("memory fault without high impedance");
  a_mem_nib_zero: assert property (
    fault_mem_double [*8] |-> status_comm_nibble == 2'h0)
    else $error("memory fault left status bits set");
  a_prog_out_hiz: assert property (prog_mode |-> out_oe_n)
    else $error("programming mode with pin driven");
  // Bus handshake behaviour
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped or changed");
  a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken during response");
  a_rd_time: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid)
    else $error("read data late");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during response");
  a_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr > 8'h10 |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  // Main scenarios
  c_prog: cover property (prog_mode);
  c_bad_wr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  c_mem_hiz: cover property (sent_hiz && out_oe_n);
endmodule : dfe_top_chk

bind dfe_top dfe_top_chk dfe_top_chk_inst (
  .clk_sys(clk_sys), .resetn(resetn), .s_axi_awready(s_axi_awready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .fault_mem_double(fault_mem_double), .out_oe_n(out_oe_n),
  .sent_hiz(sent_hiz), .status_comm_nibble(status_comm_nibble),
  .prog_mode(prog_mode));

// ---- verification/testbench.sv ----
// Self-checking bench for the fault output encoder
`timescale 1ns/10ps
`include "dfe_regs.svh"
module testbench;
  localparam int          CAR  = 10;
  localparam logic [31:0] BASE = 32'h000c_23f0;
  logic        clk_sys, resetn, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  logic        npwm, lvl, oen, shiz, prog;
  logic [7:0]  awa, ara, flt;
  logic [31:0] wd, rd, d;
  logic [1:0]  bres, rres, nib, r;
  int          n_mismatch, check_count, seed, k, hi_len, per_len;
  int          cyc = 0;
  int          duty[$] = '{404, 116, 308, 500, 596, 692, 788};
  int          fbit[$] = '{4, 3, 2, 5, 5, 6, 7};

  dfe_top dfe_top_inst (.clk_sys(clk_sys), .resetn(resetn),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_bresp(bres), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .s_axi_rdata(rd), .s_axi_rresp(rres), .fault_overvoltage(flt[0]),
    .fault_undervoltage(flt[1]), .fault_path_monitor(flt[2]),
    .fault_over_temp(flt[3]), .fault_under_temp(flt[4]),
    .fault_range_low(flt[5]), .fault_range_high(flt[6]),
    .fault_mem_double(flt[7]), .normal_pwm(npwm), .normal_sent(1'b0),
    .out_level(lvl), .out_oe_n(oen), .status_comm_nibble(nib),
    .sent_hiz(shiz), .prog_mode(prog));
  dfe_ctrl_model dfe_ctrl_model_inst (.clk_sys(clk_sys), .out_level(lvl),
    .out_oe_n(oen), .high_len(hi_len), .per_len(per_len));

  // Clock, random normal waveform and hang limit
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    npwm <= 1'($random(seed));
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      summarize();
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s seen %h exp %h", $time, m, seen, exp);
    end
  endtask : chk

  task summarize;
    $display("Counts: %0d checks, %0d mismatches", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize

  task wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : wait_cyc

  // Write with address and data offered together
  task axi_wr(input logic [7:0] a, input logic [31:0] v);
    bit ad, dd;
    ad = 0;
    dd = 0;
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge clk_sys);
      if (awv && awr) begin
        ad = 1;
        awv <= 1'b0;
      end
      if (wv && wr) begin
        dd = 1;
        wv <= 1'b0;
      end
    end
    wait_cyc($unsigned($random(seed)) % 3);
    br <= 1'b1;
    do @(posedge clk_sys); while (!bv);
    r = bres;
    br <= 1'b0;
  endtask : axi_wr

  // Read with a random late rready
  task axi_rd(input logic [7:0] a);
    ara <= a;
    arv <= 1'b1;
    do @(posedge clk_sys); while (!arr);
    arv <= 1'b0;
    wait_cyc($unsigned($random(seed)) % 3);
    rr <= 1'b1;
    do @(posedge clk_sys); while (!rv);
    d = rd;
    r = rres;
    rr <= 1'b0;
  endtask : axi_rd

  // Main sequence
  initial begin
    {resetn, awv, wv, br, arv, rr, awa, ara, wd, flt} = '0;
    {n_mismatch, check_count} = '0;
    seed = 48146;
    wait_cyc(2);
    resetn <= 1'b1;
    @(posedge clk_sys);
    axi_rd(`DFE_OFF_CONFIG);
    chk(d, `DFE_CFG_RESET, "config reset");
    axi_rd(`DFE_OFF_CARRIER);
    chk(d, 32'h0000_03e8, "carrier reset");
    axi_rd(`DFE_OFF_FAULT_WORD);
    chk(d, 32'h0, "fault word reset");
    axi_wr(`DFE_OFF_FAULT_WORD, 32'h0000_00ff);
    chk(r, 2'h2, "read-only write");
    axi_rd(8'h20);
    chk(r, 2'h2, "unmapped resp");
    chk(d, 32'h0, "unmapped data");
    axi_wr(`DFE_OFF_CARRIER, CAR);
    axi_wr(`DFE_OFF_CONFIG, BASE);
    $display("Done: registers");
    // Each fault except the memory fault alone, diagnostic waveform mode
    for (int i = 0; i < 7; i++) begin
      flt <= 8'h01 << i;
      wait_cyc(120);
      axi_rd(`DFE_OFF_FAULT_WORD);
      chk(d, 32'h1 << fbit[i], "fault word");
      chk(nib, (i == 2) ? 2'h1 : 2'h2, "nibble");
      chk(oen, 1'b0, "pin driven");
      chk(shiz, 1'b0, "serial driven");
      chk(per_len, 2 * CAR, "period");
      chk(hi_len, (2 * CAR * duty[i] + 999) / 1000, "duty");
      flt <= 8'h0;
      wait_cyc(10);
    end
    $display("Done: diagnostic waveforms");
    axi_wr(`DFE_OFF_CONFIG, BASE | 32'h400);
    for (int i = 0; i < 4; i++) begin
      k = $unsigned($random(seed)) % 7;
      flt <= 8'h01 << k;
      wait_cyc(8);
      chk(oen, 1'b1, "mode 1 hiz");
      chk(shiz, 1'b1, "mode 1 serial hiz");
      flt <= 8'h0;
      wait_cyc(8);
      chk(oen, 1'b0, "mode 1 released");
      chk(shiz, 1'b0, "mode 1 serial released");
    end
    axi_wr(`DFE_OFF_CONFIG, BASE | 32'h4);
    flt <= 8'h08;
    wait_cyc(8);
    axi_rd(`DFE_OFF_FAULT_WORD);
    chk(d, 32'h0, "disabled check");
    // OV, UV and OOR off bits set and path config 3: nothing reported
    axi_wr(`DFE_OFF_CONFIG, BASE | 32'h100b);
    flt <= 8'h67;
    wait_cyc(8);
    axi_rd(`DFE_OFF_FAULT_WORD);
    chk(d, 32'h0, "disabled faults");
    chk(oen, 1'b0, "disabled faults driven");
    chk(nib, 2'h0, "disabled faults nibble");
    $display("Done: high impedance mode");
    axi_wr(`DFE_OFF_CONFIG, BASE & 32'hfff0_ffff);
    flt <= 8'h01;
    wait_cyc(8);
    axi_rd(`DFE_OFF_FAULT_WORD);
    chk(d, 32'h0, "unlocked word");
    chk(prog, 1'b1, "programming");
    chk(oen, 1'b1, "unlocked hiz");
    axi_wr(`DFE_OFF_CONFIG, BASE);
    flt <= 8'h84;
    wait_cyc(8);
    axi_rd(`DFE_OFF_FAULT_WORD);
    chk(d[0], 1'b1, "memory bit");
    chk(oen, 1'b1, "memory hiz");
    chk(shiz, 1'b1, "memory serial hiz");
    chk(nib, 2'h0, "memory nibble");
    $display("Done: programming and memory fault");
    summarize();
  end
endmodule : testbench
